// >>> rts_cfg.svh
/*
  Constants of the reader timer slice: register indices, field positions,
  reset values and clock rates.
  Assumes it is included by its bare name wherever these names are needed.
*/
`ifndef RTS_CFG_SVH
`define RTS_CFG_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define RTS_IDX_TA_CNT_HI 6'h12
`define RTS_IDX_TA_CNT_LO 6'h13
`define RTS_IDX_TB_CTRL 6'h14
`define RTS_IDX_TB_RLD_HI 6'h15
`define RTS_IDX_TB_RLD_LO 6'h16
`define RTS_IDX_TB_CNT_HI 6'h17
`define RTS_IDX_TB_CNT_LO 6'h18
`define RTS_IDX_RUN_CTRL 6'h20
`define RTS_IDX_IRQ_STS 6'h21
`define RTS_IDX_IRQ_MASK 6'h22

// ****************************************************************
// Field positions
// ****************************************************************
`define RTS_CTRL_STOPRX_BIT 7
`define RTS_CTRL_START_LSB 4
`define RTS_CTRL_AR_BIT 3
`define RTS_CTRL_CLK_LSB 0
`define RTS_CTRL_WMASK 8'hbb
`define RTS_RUN_RUN_BIT 5
`define RTS_RUN_MASK_BIT 1
`define RTS_STS_UF_BIT 0
`define RTS_STS_TRIM_BIT 1
`define RTS_STS_RXSTOP_BIT 2

// ****************************************************************
// Reset values
// ****************************************************************
`define RTS_CTRL_RST 8'h00
`define RTS_RLD_RST 16'h0000
`define RTS_MASK_RST 3'h0

// ****************************************************************
// Clock rates in kHz, slow source divider
// ****************************************************************
`define RTS_SYS_KHZ 25000
`define RTS_FC_KHZ 13560
`define RTS_SLOW_DIV 64

`endif

// >>> rts_pkg.sv
/*
  Types of the reader timer slice.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rts_pkg;

  typedef enum logic [1:0] {
    RTS_ST_IDLE = 2'b00,
    RTS_ST_RUN = 2'b01
  } rts_state_e;

  typedef enum logic [1:0] {
    RTS_START_NONE = 2'b00,
    RTS_START_TX_END = 2'b01,
    RTS_START_TRIM = 2'b10,
    RTS_START_TRIM_UF = 2'b11
  } rts_start_e;

  typedef enum logic [1:0] {
    RTS_CLK_FC = 2'b00,
    RTS_CLK_SLOW = 2'b01,
    RTS_CLK_TA_UF = 2'b10,
    RTS_CLK_TC_UF = 2'b11
  } rts_clk_sel_e;

endpackage

// >>> rts_tick_gen.sv
/*
  Tick generator: one-cycle enables at the carrier rate and at the
  carrier rate divided down, both made from the system clock.
  Assumes a system clock faster than the carrier rate.
*/
`timescale 1ns/10ps
`include "rts_cfg.svh"

module rts_tick_gen
  import rts_pkg::*;
#(
  parameter logic [15:0] SYS_KHZ = 16'(`RTS_SYS_KHZ),
  parameter logic [15:0] FC_KHZ = 16'(`RTS_FC_KHZ),
  parameter int SLOW_DIV = `RTS_SLOW_DIV
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  output logic tick_fc_o,
  output logic tick_slow_o
);

  localparam int DW = $clog2(SLOW_DIV);

  logic [15:0] acc_q;
  logic [DW-1:0] div_q;
  logic [16:0] acc_sum;
  logic acc_wrap;

  // Fractional accumulator: the average tick rate is exact, jitter is
  // one system clock, which a count clock source tolerates.
  assign acc_sum = {1'b0, acc_q} + {1'b0, FC_KHZ};
  assign acc_wrap = acc_sum >= {1'b0, SYS_KHZ};

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      acc_q <= 16'h0000;
      tick_fc_o <= 1'b0;
    end else begin
      acc_q <= acc_wrap ? 16'(acc_sum - {1'b0, SYS_KHZ}) : acc_sum[15:0];
      tick_fc_o <= acc_wrap;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      div_q <= '0;
      tick_slow_o <= 1'b0;
    end else begin
      if (tick_fc_o) begin
        div_q <= DW'(div_q + 1'b1);
      end
      tick_slow_o <= tick_fc_o && (div_q == DW'(SLOW_DIV - 1));
    end
  end

endmodule

// >>> rts_timer.sv
/*
  Reader timer slice: readback of the first timer's count and the whole
  second timer with its control, reload, count, run control and interrupt.
  Assumes an Avalon-MM master on the system clock, and event pulses from
  the rest of the unit that are synchronous one-cycle pulses.
*/
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "rts_cfg.svh"

// How it works
// - First timer count readable as high byte then low byte, read only.
// - Second timer count high byte readable; software avoids it in reception.
// - Stop-on-receive set stops the timer after four received bits.
// - Stop-on-receive is ignored while a trimming start mode is chosen.
// - Start mode 00b starts only on a host run write; 01b also starts at end of transmission.
// - Modes 10b, 11b trim: oscillator edge starts/stops; 11b allows underflow.
// - Outside mode 10b (holds at zero), auto-restart reloads at zero and goes on; otherwise stops at zero.
// - Every underflow sets the timer interrupt request flag.
// - Clock select picks carrier, carrier/64, first or third timer underflow.
// - Each start loads the counter from the two reload bytes.
// - Reload writes leave a running count alone until the next start or auto-restart reload.
// - A host write changes the running bit only with its write-mask bit set.
module rts_timer
  import rts_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int STS_W = 3
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [15:0] timer_a_count_i,
  input wire logic timer_a_underflow_i,
  input wire logic timer_c_underflow_i,
  input wire logic tx_end_i,
  input wire logic rx_first_bits_i,
  input wire logic low_freq_osc_edge_i,
  output logic timer_b_running_o,
  output logic timer_b_underflow_o,
  output logic irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [7:0] rld_hi_q;
  logic [7:0] rld_lo_q;
  logic [STS_W-1:0] mask_q;
  logic [STS_W-1:0] sts_q;
  logic [STS_W-1:0] sts_d;
  logic [STS_W-1:0] sts_set;
  logic [STS_W-1:0] sts_clr;
  logic irq_q;
  logic run_q;
  logic uf_q;
  rts_state_e st_q;
  rts_state_e st_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic uf_d;
  logic trim_done_d;
  logic rx_stop_d;

  logic tick_fc;
  logic tick_slow;

  logic [5:0] reg_idx;
  logic req;
  logic acc_go;
  logic wr_go;
  logic rd_go;
  logic [7:0] wdat;
  logic hit_ta_hi;
  logic hit_ta_lo;
  logic hit_ctl;
  logic hit_rld_hi;
  logic hit_rld_lo;
  logic hit_tb_hi;
  logic hit_tb_lo;
  logic hit_run;
  logic hit_sts;
  logic hit_mask;
  logic [7:0] rd_byte;
  logic [7:0] run_byte;

  logic stop_rx_en;
  rts_start_e start_mode;
  rts_clk_sel_e clk_sel;
  logic auto_restart;
  logic trim_mode;
  logic [CNT_W-1:0] reload_val;
  logic host_run_wr;
  logic host_run_val;
  logic rx_stop;
  logic auto_start;
  logic lfo_hit;
  logic tick;
  logic at_zero;

  // ****************************************************************
  // Count clock sources
  // ****************************************************************
  rts_tick_gen u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tick_fc_o(tick_fc),
    .tick_slow_o(tick_slow)
  );

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Word aligned registers; the two low address bits are ignored.
  assign reg_idx = avs_address_i[7:2];
  assign req = avs_read_i | avs_write_i;
  assign acc_go = req & ~wait_q;
  assign wr_go = acc_go & avs_write_i & avs_byteenable_i[0];
  assign rd_go = acc_go & avs_read_i;
  assign wdat = avs_writedata_i[7:0];

  assign hit_ta_hi = reg_idx == `RTS_IDX_TA_CNT_HI;
  assign hit_ta_lo = reg_idx == `RTS_IDX_TA_CNT_LO;
  assign hit_ctl = reg_idx == `RTS_IDX_TB_CTRL;
  assign hit_rld_hi = reg_idx == `RTS_IDX_TB_RLD_HI;
  assign hit_rld_lo = reg_idx == `RTS_IDX_TB_RLD_LO;
  assign hit_tb_hi = reg_idx == `RTS_IDX_TB_CNT_HI;
  assign hit_tb_lo = reg_idx == `RTS_IDX_TB_CNT_LO;
  assign hit_run = reg_idx == `RTS_IDX_RUN_CTRL;
  assign hit_sts = reg_idx == `RTS_IDX_IRQ_STS;
  assign hit_mask = reg_idx == `RTS_IDX_IRQ_MASK;

  // Run control reads back only the running bit, at its write position.
  assign run_byte = 8'(run_q) << `RTS_RUN_RUN_BIT;

  // Count bytes are live values; during reception they may be stale.
  assign rd_byte =
    hit_ta_hi ? timer_a_count_i[15:8] :
    hit_ta_lo ? timer_a_count_i[7:0] :
    hit_ctl ? ctl_q :
    hit_rld_hi ? rld_hi_q :
    hit_rld_lo ? rld_lo_q :
    hit_tb_hi ? cnt_q[15:8] :
    hit_tb_lo ? cnt_q[7:0] :
    hit_run ? run_byte :
    hit_sts ? 8'(sts_q) :
    hit_mask ? 8'(mask_q) :
    8'h00;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Waitrequest drops for one cycle after a request is seen, so every
  // access completes at the second edge of the request.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ****************************************************************
  // Control and reload registers
  // ****************************************************************
  // Reserved bits 6 and 2 are dropped so that they always read as zero.
  assign ctl_d = wdat & `RTS_CTRL_WMASK;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctl_q <= `RTS_CTRL_RST;
      rld_hi_q <= 8'(`RTS_RLD_RST >> 8);
      rld_lo_q <= 8'(`RTS_RLD_RST);
      mask_q <= `RTS_MASK_RST;
    end else begin
      if (wr_go && hit_ctl) begin
        ctl_q <= ctl_d;
      end
      if (wr_go && hit_rld_hi) begin
        rld_hi_q <= wdat;
      end
      if (wr_go && hit_rld_lo) begin
        rld_lo_q <= wdat;
      end
      if (wr_go && hit_mask) begin
        mask_q <= wdat[STS_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Control fields and events
  // ****************************************************************
  assign stop_rx_en = ctl_q[`RTS_CTRL_STOPRX_BIT];
  assign start_mode = rts_start_e'(ctl_q[`RTS_CTRL_START_LSB +: 2]);
  assign auto_restart = ctl_q[`RTS_CTRL_AR_BIT];
  assign clk_sel = rts_clk_sel_e'(ctl_q[`RTS_CTRL_CLK_LSB +: 2]);
  assign trim_mode = start_mode[1];
  assign reload_val = {rld_hi_q, rld_lo_q};

  // A run write without its mask bit leaves the timer as it is.
  assign host_run_wr = wr_go & hit_run & wdat[`RTS_RUN_MASK_BIT];
  assign host_run_val = wdat[`RTS_RUN_RUN_BIT];
  assign rx_stop = stop_rx_en & ~trim_mode & rx_first_bits_i;
  assign auto_start = (start_mode == RTS_START_TX_END) & tx_end_i;
  assign lfo_hit = trim_mode & low_freq_osc_edge_i;

  // Cascade sources are one-cycle underflow pulses of the sibling timers.
  assign tick =
    (clk_sel == RTS_CLK_FC) ? tick_fc :
    (clk_sel == RTS_CLK_SLOW) ? tick_slow :
    (clk_sel == RTS_CLK_TA_UF) ? timer_a_underflow_i :
    timer_c_underflow_i;

  assign at_zero = cnt_q == '0;

  // ****************************************************************
  // Timer state machine
  // ****************************************************************
  // Priority: host run write, then stop events, then start events, then
  // the count tick, so a stop never loses to a tick in the same cycle.
  // Limitation: a zero reload with auto-restart underflows on every tick,
  // so the cascade output may then stay high for several cycles.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    uf_d = 1'b0;
    trim_done_d = 1'b0;
    rx_stop_d = 1'b0;
    case (st_q)
      RTS_ST_IDLE: begin
        if (host_run_wr) begin
          if (host_run_val) begin
            st_d = RTS_ST_RUN;
            cnt_d = reload_val;
          end
        end else if (auto_start || lfo_hit) begin
          st_d = RTS_ST_RUN;
          cnt_d = reload_val;
        end
      end
      RTS_ST_RUN: begin
        if (host_run_wr) begin
          if (host_run_val) begin
            cnt_d = reload_val;
          end else begin
            st_d = RTS_ST_IDLE;
          end
        end else if (rx_stop) begin
          st_d = RTS_ST_IDLE;
          rx_stop_d = 1'b1;
        end else if (lfo_hit) begin
          st_d = RTS_ST_IDLE;
          trim_done_d = 1'b1;
        end else if (auto_start) begin
          cnt_d = reload_val;
        end else if (tick) begin
          if (!at_zero) begin
            cnt_d = CNT_W'(cnt_q - 1'b1);
          end else if (start_mode == RTS_START_TRIM) begin
            // Trimming without underflow holds at zero until the edge.
            cnt_d = cnt_q;
          end else begin
            uf_d = 1'b1;
            if (auto_restart) begin
              cnt_d = reload_val;
            end else begin
              st_d = RTS_ST_IDLE;
            end
          end
        end
      end
      default: begin
        st_d = RTS_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q <= RTS_ST_IDLE;
      cnt_q <= '0;
      run_q <= 1'b0;
      uf_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      run_q <= st_d == RTS_ST_RUN;
      uf_q <= uf_d;
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // The interrupt is taken from the next status, so it rises with the flag.
  assign sts_set[`RTS_STS_UF_BIT] = uf_d;
  assign sts_set[`RTS_STS_TRIM_BIT] = trim_done_d;
  assign sts_set[`RTS_STS_RXSTOP_BIT] = rx_stop_d;

  // Only bits already returned to software are cleared, so an event
  // landing between data capture and completion is not lost.
  assign sts_clr = (rd_go && hit_sts) ? rdata_q[STS_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < STS_W; gi++) begin : g_sts
      assign sts_d[gi] = sts_set[gi] | (sts_q[gi] & ~sts_clr[gi]);
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      sts_q <= '0;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= |(sts_d & mask_q);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign timer_b_running_o = run_q;
  assign timer_b_underflow_o = uf_q;
  assign irq_o = irq_q;

endmodule

// >>> rts_timer_chk.sv
/*
  Port checker for the reader timer slice.
  Assumes it is bound to rts_timer and sees only its ports.
*/
`timescale 1ns/10ps
`include "rts_cfg.svh"

module rts_timer_chk
  import rts_pkg::*;
(
  input logic clk_sys_i,
  input logic rst_n_i,
  input logic [7:0] avs_address_i,
  input logic avs_read_i,
  input logic avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0] avs_byteenable_i,
  input logic [31:0] avs_readdata_o,
  input logic avs_waitrequest_o,
  input logic [15:0] timer_a_count_i,
  input logic timer_a_underflow_i,
  input logic timer_c_underflow_i,
  input logic tx_end_i,
  input logic rx_first_bits_i,
  input logic low_freq_osc_edge_i,
  input logic timer_b_running_o,
  input logic timer_b_underflow_o,
  input logic irq_o
);
  // ****************************************************************
  // Decodes of a completing bus cycle
  // ****************************************************************
  wire fin_w = !avs_waitrequest_o && (avs_read_i || avs_write_i);
  wire [5:0] idx_w = avs_address_i[7:2];
  wire [7:0] ta_hi_w = timer_a_count_i[15:8];
  wire [7:0] ta_lo_w = timer_a_count_i[7:0];
  wire rd_w = fin_w && avs_read_i;
  wire wr_w = fin_w && avs_write_i && avs_byteenable_i[0];
  wire rd_sts_w = rd_w && idx_w == `RTS_IDX_IRQ_STS;
  wire wr_msk_w = wr_w && idx_w == `RTS_IDX_IRQ_MASK;
  wire wr_run_w = wr_w && idx_w == `RTS_IDX_RUN_CTRL;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_wait_prompt:
    assert property ($rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  a_wait_single:
    assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause:
    assert property (!avs_waitrequest_o |-> avs_read_i || avs_write_i)
    else $error("waitrequest low with no request");
  a_rd_upper:
    assert property (rd_w |-> avs_readdata_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_ta_high:
    assert property (rd_w && idx_w == `RTS_IDX_TA_CNT_HI
      |-> avs_readdata_o[7:0] == $past(ta_hi_w))
    else $error("first timer high byte wrong");
  a_ta_low:
    assert property (rd_w && idx_w == `RTS_IDX_TA_CNT_LO
      |-> avs_readdata_o[7:0] == $past(ta_lo_w))
    else $error("first timer low byte wrong");
  a_run_write:
    assert property (wr_run_w && avs_writedata_i[1]
      |=> timer_b_running_o == $past(avs_writedata_i[5]))
    else $error("running bit not taken from masked write");
  a_uf_single:
    assert property (timer_b_underflow_o |=> !timer_b_underflow_o)
    else $error("underflow pulse longer than one cycle");
  a_uf_running:
    assert property ($rose(timer_b_underflow_o) |-> $past(timer_b_running_o))
    else $error("underflow while timer idle");
  a_irq_fall:
    assert property ($fell(irq_o) |-> $past(rd_sts_w) || $past(wr_msk_w)
      || $past(rd_sts_w, 2) || $past(wr_msk_w, 2))
    else $error("interrupt dropped without status read or mask write");

  c_uf: cover property (timer_b_underflow_o);
  c_irq: cover property ($rose(irq_o));
  c_run: cover property ($rose(timer_b_running_o));
  c_sts: cover property (rd_sts_w && irq_o);
endmodule

bind rts_timer rts_timer_chk u_chk (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .timer_a_count_i(timer_a_count_i),
  .timer_a_underflow_i(timer_a_underflow_i),
  .timer_c_underflow_i(timer_c_underflow_i), .tx_end_i(tx_end_i),
  .rx_first_bits_i(rx_first_bits_i),
  .low_freq_osc_edge_i(low_freq_osc_edge_i),
  .timer_b_running_o(timer_b_running_o),
  .timer_b_underflow_o(timer_b_underflow_o), .irq_o(irq_o));

// >>> test_reader_timer_slice.sv
/*
  Self-checking bench for the reader timer slice.
  Assumes rts_pkg, rts_timer and the checker are compiled before it.
*/
`timescale 1ns/10ps
`include "rts_cfg.svh"

module test_reader_timer_slice
  import rts_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [5:0] i;
    logic [7:0] d;
    logic [7:0] e;
  } rts_row_s;

  localparam logic [5:0] CT = `RTS_IDX_TB_CTRL;
  localparam logic [5:0] RH = `RTS_IDX_TB_RLD_HI;
  localparam logic [5:0] RL = `RTS_IDX_TB_RLD_LO;
  localparam logic [5:0] RN = `RTS_IDX_RUN_CTRL;
  localparam logic [5:0] ST = `RTS_IDX_IRQ_STS;
  localparam logic [5:0] MK = `RTS_IDX_IRQ_MASK;
  localparam rts_row_s ROWS [9] = '{
    '{1'b1, CT, 8'hff, 8'hbb},
    '{1'b1, CT, 8'h00, 8'h00},
    '{1'b1, RH, 8'ha5, 8'ha5},
    '{1'b1, RL, 8'h5a, 8'h5a},
    '{1'b1, `RTS_IDX_TA_CNT_HI, 8'hff, 8'h12},
    '{1'b0, `RTS_IDX_TA_CNT_LO, 8'h00, 8'h34},
    '{1'b1, `RTS_IDX_TB_CNT_HI, 8'hff, 8'h00},
    '{1'b1, 6'h3f, 8'hff, 8'h00},
    '{1'b1, MK, 8'h07, 8'h07}};

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [4:0] ev = 5'h00;
  logic [15:0] ta_cnt = 16'h1234;
  logic [31:0] rdata;
  logic wreq;
  logic run;
  logic uf;
  logic irq;
  logic [7:0] q;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  rts_timer DUT (.clk_sys_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(we), .avs_writedata_i({24'h0, wd}),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .timer_a_count_i(ta_cnt),
    .timer_a_underflow_i(ev[3]), .timer_c_underflow_i(ev[4]),
    .tx_end_i(ev[0]), .rx_first_bits_i(ev[1]),
    .low_freq_osc_edge_i(ev[2]), .timer_b_running_o(run),
    .timer_b_underflow_o(uf), .irq_o(irq));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task give_verdict;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [5:0] i,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= {i, 2'b00};
    wd <= d;
    we <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 64);
    q = rdata[7:0];
    we <= 1'b0;
    rd <= 1'b0;
    if (n >= 64)
      chk(8'h01, 8'h00);
  endtask

  task wrr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask

  task rdc(input logic [5:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(q, e);
  endtask

  task rn(input logic e);
    @(negedge clk);
    chk({7'h0, run}, {7'h0, e});
  endtask

  task pulse(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  // Bounded wait; the slowest source ticks every 118 cycles or so
  task automatic wuf;
    int n;
    n = 0;
    while (uf !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000)
      chk(8'h01, 8'h00);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      give_verdict;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // No reception runs while any count byte is read back
    foreach (ROWS[k]) begin
      if (ROWS[k].w)
        wrr(ROWS[k].i, ROWS[k].d);
      rdc(ROWS[k].i, ROWS[k].e);
    end
    ta_cnt <= 16'hbeef;
    rdc(`RTS_IDX_TA_CNT_HI, 8'hbe);
    rdc(`RTS_IDX_TA_CNT_LO, 8'hef);
    $display("register table done");
    wrr(RH, 8'h00);
    wrr(RL, 8'h02);
    wrr(MK, 8'h01);
    wrr(RN, 8'h20);
    rn(1'b0);
    wrr(RN, 8'h22);
    rn(1'b1);
    wuf;
    @(negedge clk);
    chk({7'h0, irq}, 8'h01);
    repeat (8) @(posedge clk);
    rn(1'b0);
    rdc(ST, 8'h01);
    rdc(ST, 8'h00);
    chk({7'h0, irq}, 8'h00);
    wrr(CT, 8'h08);
    wrr(RN, 8'h22);
    wuf;
    @(posedge clk);
    wuf;
    rn(1'b1);
    wrr(RN, 8'h02);
    rn(1'b0);
    rdc(ST, 8'h01);
    $display("underflow test done");
    wrr(RH, 8'h40);
    wrr(RL, 8'hff);
    wrr(CT, 8'h01);
    wrr(RN, 8'h22);
    wrr(RH, 8'h10);
    rdc(`RTS_IDX_TB_CNT_HI, 8'h40);
    wrr(RN, 8'h02);
    wrr(RN, 8'h22);
    rdc(`RTS_IDX_TB_CNT_HI, 8'h10);
    wrr(RN, 8'h02);
    $display("reload test done");
    wrr(CT, 8'h00);
    pulse(0);
    rn(1'b0);
    wrr(CT, 8'h10);
    pulse(0);
    rn(1'b1);
    pulse(1);
    rn(1'b1);
    wrr(CT, 8'h90);
    pulse(1);
    rn(1'b0);
    rdc(ST, 8'h04);
    wrr(CT, 8'ha0);
    pulse(2);
    rn(1'b1);
    pulse(1);
    rn(1'b1);
    pulse(2);
    rn(1'b0);
    rdc(ST, 8'h02);
    $display("start mode test done");
    wrr(RH, 8'h00);
    wrr(RL, 8'h01);
    for (int k = 2; k < 4; k++) begin
      wrr(CT, 8'(k));
      wrr(RN, 8'h22);
      repeat (20) @(posedge clk);
      rn(1'b1);
      pulse(k + 1);
      pulse(k + 1);
      rn(1'b0);
      rdc(ST, 8'h01);
    end
    $display("cascade clock test done");
    // Trimming without underflow: the count rests at zero until the edge
    wrr(CT, 8'h20);
    pulse(2);
    repeat (20) @(posedge clk);
    rn(1'b1);
    rdc(`RTS_IDX_TB_CNT_LO, 8'h00);
    rdc(ST, 8'h00);
    pulse(2);
    rn(1'b0);
    rdc(ST, 8'h02);
    wrr(CT, 8'h30);
    pulse(2);
    wuf;
    rn(1'b0);
    rdc(ST, 8'h01);
    $display("trim mode test done");
    wrr(CT, 8'h08);
    wrr(RN, 8'h22);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rn(1'b0);
    rdc(CT, 8'h00);
    rdc(MK, 8'h00);
    rdc(RH, 8'h00);
    $display("reset test done");
    give_verdict;
  end
endmodule
